// [inc/bridge_dp_pkg.sv]
// Shared constants for the bridge data-path slice: widths, command codes,
// pipeline lags, line geometry and reset values.
// Assumes one core clock shared by the host, memory and PCI facing logic.
package bridge_dp_pkg;
   localparam int DATA_W = 32;
   localparam int PAR_W = 4;
   localparam int BYTE_W = 8;
   localparam int HCMD_W = 5;
   localparam int MCMD_W = 3;
   localparam int PCMD_W = 4;
   localparam int PF_DEPTH = 4;
   localparam int PF_PTR_W = 2;
   localparam int WBUF_DEPTH = 2;
   // Host bus lags after a drive command is sampled, in core cycles
   localparam int HOST_ADDR_LAG = 1;
   localparam int HOST_DATA_LAG = 2;
   // Cache line geometry used by the end-of-line tracker
   localparam int LINE_DW = 8;
   localparam int LINE_IDX_W = 3;
   localparam int LINE_IDX_LSB = 2;
   localparam int LINE_CNT_W = 4;
   localparam logic [LINE_CNT_W-1:0] LINE_CNT_RST = 4'h0;
   localparam logic EOL_RST = 1'b0;
   // Host command codes
   localparam logic [HCMD_W-1:0] HOST_IDLE_CMD = 5'h00;
   localparam logic [HCMD_W-1:0] CPU_MEM_READ_CMD = 5'h01;
   localparam logic [HCMD_W-1:0] HOST_PREFETCH_FIRST_CMD = 5'h02;
   localparam logic [HCMD_W-1:0] HOST_PREFETCH_TOGGLE_A_CMD = 5'h03;
   localparam logic [HCMD_W-1:0] HOST_PREFETCH_TOGGLE_B_CMD = 5'h04;
   // Memory command codes
   localparam logic [MCMD_W-1:0] MEM_IDLE_CMD = 3'h0;
   localparam logic [MCMD_W-1:0] MEM_HOLD_DRIVE_CMD = 3'h1;
   localparam logic [MCMD_W-1:0] MEM_READ_FIRST_QW_LATCH = 3'h2;
   localparam logic [MCMD_W-1:0] MEM_READ_NEXT_QW_LATCH = 3'h3;
   localparam logic [MCMD_W-1:0] RETIRE_CPU_WRITE_QW = 3'h4;
   localparam logic [MCMD_W-1:0] RETIRE_PCI_WRITE_QW = 3'h5;
   localparam logic [MCMD_W-1:0] RETIRE_PCI_WRITE_QW_SPLIT = 3'h6;
   // PCI command codes
   localparam logic [PCMD_W-1:0] PREFETCH_LATCH_FIRST = 4'h0;
   localparam logic [PCMD_W-1:0] PREFETCH_LATCH_TOGGLE_A = 4'h1;
   localparam logic [PCMD_W-1:0] PREFETCH_LATCH_TOGGLE_B = 4'h2;
   localparam logic [PCMD_W-1:0] LATCH_MASTER_ADDR_CMD = 4'h3;
   localparam logic [PCMD_W-1:0] POST_WRITE_ADDR_CMD = 4'h8;
   localparam logic [PCMD_W-1:0] POST_WRITE_DATA_CMD = 4'h9;
   // One bit per PCI code: parity taken from the driven value
   localparam logic [15:0] PCI_PAR_OUT_MAP = 16'h7CF0;
   // One bit per PCI code: command loads outbound AD data
   localparam logic [15:0] PCI_DRIVE_MAP = 16'h70F0;
   // One bit per PCI code: command consumes one dword of the line
   localparam logic [15:0] PCI_EOL_DEC_MAP = 16'h7300;
endpackage

// [verilog/data_skid_fifo.sv]
// Small FIFO with valid/ready on both sides; full and empty are exact.
// Assumes the drain side may stall for any number of cycles.
`timescale 1ns/1ps
`default_nettype none
module data_skid_fifo #(
   parameter int DW = 36,
   parameter int DEPTH = 2
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [DW-1:0] i_in_data,
   input wire logic i_in_valid,
   output logic o_in_ready,
   output logic [DW-1:0] o_out_data,
   output logic o_out_valid,
   input wire logic i_out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [DW-1:0] slot_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_reg != '0);
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = slot_reg[rd_reg];

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         slot_reg[wr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_reg + 1'b1);
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_reg + 1'b1);
         end
         cnt_reg <= (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
      end
   end
endmodule
`default_nettype wire

// [verilog/read_prefetch_buffer.sv]
// Four-dword read prefetch buffer with toggle-driven write and read pointers.
// Assumes the write and read command strobes are one-hot per cycle.
`timescale 1ns/1ps
`default_nettype none
module read_prefetch_buffer (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wr_first,
   input wire logic i_wr_a,
   input wire logic i_wr_b,
   input wire logic [bridge_dp_pkg::DATA_W-1:0] i_wr_data,
   input wire logic i_rd_first,
   input wire logic i_rd_a,
   input wire logic i_rd_b,
   output logic [bridge_dp_pkg::DATA_W-1:0] o_rd_data,
   output logic [bridge_dp_pkg::PF_PTR_W-1:0] o_wr_ptr
);
   import bridge_dp_pkg::*;
   typedef enum logic [1:0] {TOG_NONE, TOG_FIRST, TOG_A, TOG_B} tog_type;
   tog_type wr_tog_reg, wr_tog_next, rd_tog_reg, rd_tog_next;
   logic [DATA_W-1:0] entry_reg [PF_DEPTH];
   logic [PF_PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;

   always_comb begin
      wr_tog_next = i_wr_first ? TOG_FIRST : i_wr_a ? TOG_A : i_wr_b ? TOG_B : TOG_NONE;
      rd_tog_next = i_rd_first ? TOG_FIRST : i_rd_a ? TOG_A : i_rd_b ? TOG_B : TOG_NONE;
      // A changed toggle moves on one dword; a repeat keeps the slot
      wr_ptr_next = wr_ptr_reg;
      if (wr_tog_next == TOG_FIRST) begin
         wr_ptr_next = '0;
      end else if (wr_tog_next != TOG_NONE && wr_tog_next != wr_tog_reg) begin
         wr_ptr_next = PF_PTR_W'(wr_ptr_reg + 1'b1);
      end
      rd_ptr_next = rd_ptr_reg;
      if (rd_tog_next == TOG_FIRST) begin
         rd_ptr_next = '0;
      end else if (rd_tog_next != TOG_NONE && rd_tog_next != rd_tog_reg) begin
         rd_ptr_next = PF_PTR_W'(rd_ptr_reg + 1'b1);
      end
   end

   for (genvar e = 0; e < PF_DEPTH; e++) begin : g_entry
      always_ff @(posedge i_core_clk) begin
         if (i_rst) begin
            entry_reg[e] <= '0;
         end else if (wr_tog_next != TOG_NONE && wr_ptr_next == PF_PTR_W'(e)) begin
            entry_reg[e] <= i_wr_data;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
         wr_tog_reg <= TOG_NONE;
      end else if (wr_tog_next != TOG_NONE) begin
         wr_ptr_reg <= wr_ptr_next;
         wr_tog_reg <= wr_tog_next;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rd_ptr_reg <= '0;
         rd_tog_reg <= TOG_NONE;
      end else if (rd_tog_next != TOG_NONE) begin
         rd_ptr_reg <= rd_ptr_next;
         rd_tog_reg <= rd_tog_next;
      end
   end

   // Live view of the slot, so a PCI re-latch shows on the host at once
   assign o_rd_data = entry_reg[rd_ptr_reg];
   assign o_wr_ptr = wr_ptr_reg;
endmodule
`default_nettype wire

// [verilog/bridge_datapath_command_timing.sv]
// Command-driven data-path slice: host, memory and PCI bus drive/latch timing,
// PCI parity, read prefetch buffer and end-of-line tracking.
// Assumes the controller drives all command lines synchronous to i_core_clk.
//
// Behaviour
// - Host address drives 1 cycle, data 2 cycles later
// - Host idle command releases host address bus within one cycle
// - Memory read command drives memory register onto host
// - Memory register loads only while latch enable high
// - Host data released on idle plus latch enable
// - Memory latch command captures memory data bus
// - Memory retire command starts driving memory bus
// - Hold-drive keeps retired data on memory bus
// - Memory idle command releases memory data bus
// - PCI drive enable drives AD next cycle
// - Drive enable low releases AD same cycle
// - Inbound PCI parity valid one clock after data
// - Outbound PCI parity valid with driven data
// - Repeated prefetch latch overwrites same slot
// - Changed prefetch latch advances to next dword
// - Host prefetch read repeats or advances by toggle
// - Host prefetch read shows live slot content
// - Track master address bits, drive end-of-line warning
// - Prefetch latch codes are 0, 1 and 2
// - Address latch sets warning if last dword
`timescale 1ns/1ps
`default_nettype none
module bridge_datapath_command_timing (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [bridge_dp_pkg::HCMD_W-1:0] i_host_cmd_lines,
   input wire logic i_mem_data_latch_en,
   output logic o_host_addr_oe,
   output logic [bridge_dp_pkg::DATA_W-1:0] o_host_data_bus,
   output logic [bridge_dp_pkg::PAR_W-1:0] o_host_parity_bus,
   output logic o_host_data_oe,
   input wire logic [bridge_dp_pkg::MCMD_W-1:0] i_mem_cmd_lines,
   input wire logic [bridge_dp_pkg::DATA_W-1:0] i_mem_data_bus,
   input wire logic [bridge_dp_pkg::PAR_W-1:0] i_mem_parity_bus,
   output logic [bridge_dp_pkg::DATA_W-1:0] o_mem_data_bus,
   output logic [bridge_dp_pkg::PAR_W-1:0] o_mem_parity_bus,
   output logic o_mem_data_oe,
   output logic [bridge_dp_pkg::DATA_W-1:0] o_mem_read_data,
   output logic o_mem_read_valid,
   input wire logic [bridge_dp_pkg::DATA_W-1:0] i_wr_data,
   input wire logic [bridge_dp_pkg::PAR_W-1:0] i_wr_parity,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [bridge_dp_pkg::PCMD_W-1:0] i_pci_cmd_lines,
   input wire logic i_pci_drive_enable,
   input wire logic [bridge_dp_pkg::DATA_W-1:0] i_pci_ad,
   input wire logic [bridge_dp_pkg::DATA_W-1:0] i_pci_tx_data,
   output logic [bridge_dp_pkg::DATA_W-1:0] o_pci_ad,
   output logic o_pci_ad_oe,
   output logic [bridge_dp_pkg::PAR_W-1:0] o_pci_parity_out,
   output logic o_end_of_line_warning,
   output logic [bridge_dp_pkg::DATA_W-1:0] o_post_write_addr
);
   import bridge_dp_pkg::*;

   // Host command decode
   logic host_idle, host_cmr, host_pf_first, host_pf_a, host_pf_b, host_drive;
   assign host_idle = (i_host_cmd_lines == HOST_IDLE_CMD);
   assign host_cmr = (i_host_cmd_lines == CPU_MEM_READ_CMD);
   assign host_pf_first = (i_host_cmd_lines == HOST_PREFETCH_FIRST_CMD);
   assign host_pf_a = (i_host_cmd_lines == HOST_PREFETCH_TOGGLE_A_CMD);
   assign host_pf_b = (i_host_cmd_lines == HOST_PREFETCH_TOGGLE_B_CMD);
   assign host_drive = host_cmr || host_pf_first || host_pf_a || host_pf_b;

   // Memory command decode
   logic mem_idle, mem_hold, mem_latch, mem_retire;
   assign mem_idle = (i_mem_cmd_lines == MEM_IDLE_CMD);
   assign mem_hold = (i_mem_cmd_lines == MEM_HOLD_DRIVE_CMD);
   assign mem_latch = (i_mem_cmd_lines == MEM_READ_FIRST_QW_LATCH) ||
                      (i_mem_cmd_lines == MEM_READ_NEXT_QW_LATCH);
   assign mem_retire = (i_mem_cmd_lines == RETIRE_CPU_WRITE_QW) ||
                       (i_mem_cmd_lines == RETIRE_PCI_WRITE_QW) ||
                       (i_mem_cmd_lines == RETIRE_PCI_WRITE_QW_SPLIT);

   // PCI command decode
   logic pf_first, pf_a, pf_b, pci_latch_master_addr_cmd, pci_post_addr;
   assign pf_first = (i_pci_cmd_lines == PREFETCH_LATCH_FIRST);
   assign pf_a = (i_pci_cmd_lines == PREFETCH_LATCH_TOGGLE_A);
   assign pf_b = (i_pci_cmd_lines == PREFETCH_LATCH_TOGGLE_B);
   assign pci_latch_master_addr_cmd = (i_pci_cmd_lines == LATCH_MASTER_ADDR_CMD);
   assign pci_post_addr = (i_pci_cmd_lines == POST_WRITE_ADDR_CMD);

   // Byte parity for the AD, transmit and prefetch sources that feed a parity output
   logic [DATA_W-1:0] pf_rd_data, pci_tx_reg;
   logic [PAR_W-1:0] ad_par, tx_par, pf_par;
   for (genvar b = 0; b < PAR_W; b++) begin : g_par
      assign ad_par[b] = ^i_pci_ad[BYTE_W*b +: BYTE_W];
      assign tx_par[b] = ^pci_tx_reg[BYTE_W*b +: BYTE_W];
      assign pf_par[b] = ^pf_rd_data[BYTE_W*b +: BYTE_W];
   end

   // Host side
   logic host_addr_oe_reg, host_data_arm_reg, host_data_oe_reg, host_src_pf_reg;
   logic [PAR_W+DATA_W-1:0] mem_hold_reg;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         host_addr_oe_reg <= 1'b0;
      end else if (host_drive) begin
         host_addr_oe_reg <= 1'b1;
      end else if (host_idle) begin
         host_addr_oe_reg <= 1'b0;
      end
   end

   // Second stage gives the data bus its extra cycle over the address
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         host_data_arm_reg <= 1'b0;
      end else begin
         host_data_arm_reg <= host_drive;
      end
   end

   // Data waits for the latch enable so the cache write strobes get hold time
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         host_data_oe_reg <= 1'b0;
      end else if (host_data_arm_reg) begin
         host_data_oe_reg <= 1'b1;
      end else if (host_idle && i_mem_data_latch_en) begin
         host_data_oe_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         host_src_pf_reg <= 1'b0;
      end else if (host_drive) begin
         host_src_pf_reg <= !host_cmr;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         mem_hold_reg <= '0;
      end else if (i_mem_data_latch_en) begin
         mem_hold_reg <= {i_mem_parity_bus, i_mem_data_bus};
      end
   end

   // Memory path is driven even before its data is valid
   assign o_host_data_bus = host_src_pf_reg ? pf_rd_data : mem_hold_reg[DATA_W-1:0];
   assign o_host_parity_bus = host_src_pf_reg ? pf_par : mem_hold_reg[PAR_W+DATA_W-1:DATA_W];
   assign o_host_addr_oe = host_addr_oe_reg;
   assign o_host_data_oe = host_data_oe_reg;

   // Memory side
   logic [DATA_W-1:0] mem_rd_reg;
   logic mem_rd_valid_reg, mem_oe_reg;
   logic [PAR_W+DATA_W-1:0] mem_out_reg, wbuf_data;
   logic wbuf_valid;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         mem_rd_reg <= '0;
         mem_rd_valid_reg <= 1'b0;
      end else begin
         mem_rd_valid_reg <= mem_latch;
         if (mem_latch) begin
            mem_rd_reg <= i_mem_data_bus;
         end
      end
   end

   // Retire pops one word; a retire with nothing queued re-drives the last word
   data_skid_fifo #(
      .DW(PAR_W + DATA_W),
      .DEPTH(WBUF_DEPTH)
   ) u_write_buf (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_in_data({i_wr_parity, i_wr_data}),
      .i_in_valid(i_wr_valid),
      .o_in_ready(o_wr_ready),
      .o_out_data(wbuf_data),
      .o_out_valid(wbuf_valid),
      .i_out_ready(mem_retire)
   );

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         mem_out_reg <= '0;
      end else if (mem_retire && wbuf_valid) begin
         mem_out_reg <= wbuf_data;
      end
   end

   // The turnaround gap is the controller's; the idle command it sends frees the bus
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         mem_oe_reg <= 1'b0;
      end else if (mem_retire) begin
         mem_oe_reg <= 1'b1;
      end else if (mem_idle) begin
         mem_oe_reg <= 1'b0;
      end
   end

   assign o_mem_data_bus = mem_out_reg[DATA_W-1:0];
   assign o_mem_parity_bus = mem_out_reg[PAR_W+DATA_W-1:DATA_W];
   assign o_mem_data_oe = mem_oe_reg;
   assign o_mem_read_data = mem_rd_reg;
   assign o_mem_read_valid = mem_rd_valid_reg;

   // PCI side
   logic pci_drv_reg, par_sel_out_reg;
   logic [PAR_W-1:0] par_in_reg;
   logic [DATA_W-1:0] ad_latch_reg;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pci_drv_reg <= 1'b0;
      end else begin
         pci_drv_reg <= i_pci_drive_enable;
      end
   end

   // Release bypasses the flop so AD lets go in the cycle enable drops
   assign o_pci_ad_oe = pci_drv_reg && i_pci_drive_enable;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pci_tx_reg <= '0;
      end else if (PCI_DRIVE_MAP[i_pci_cmd_lines]) begin
         pci_tx_reg <= i_pci_tx_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ad_latch_reg <= '0;
         par_in_reg <= '0;
         par_sel_out_reg <= 1'b0;
      end else begin
         ad_latch_reg <= i_pci_ad;
         par_in_reg <= ad_par;
         par_sel_out_reg <= PCI_PAR_OUT_MAP[i_pci_cmd_lines];
      end
   end

   assign o_pci_parity_out = par_sel_out_reg ? tx_par : par_in_reg;
   assign o_pci_ad = pci_tx_reg;

   logic [PF_PTR_W-1:0] pf_wr_ptr;
   read_prefetch_buffer u_prefetch (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_wr_first(pf_first),
      .i_wr_a(pf_a),
      .i_wr_b(pf_b),
      .i_wr_data(i_pci_ad),
      .i_rd_first(host_pf_first),
      .i_rd_a(host_pf_a),
      .i_rd_b(host_pf_b),
      .o_rd_data(pf_rd_data),
      .o_wr_ptr(pf_wr_ptr)
   );

   // End-of-line tracking for PCI master transfers
   logic [DATA_W-1:0] master_addr_reg, post_addr_reg;
   logic [LINE_CNT_W-1:0] line_left_reg;
   logic eol_reg;
   logic [LINE_IDX_W-1:0] latch_master_addr_cmd_idx;
   assign latch_master_addr_cmd_idx = ad_latch_reg[LINE_IDX_LSB +: LINE_IDX_W];

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         master_addr_reg <= '0;
         line_left_reg <= LINE_CNT_RST;
         eol_reg <= EOL_RST;
      end else if (pci_latch_master_addr_cmd) begin
         master_addr_reg <= ad_latch_reg;
         line_left_reg <= LINE_CNT_W'(LINE_DW) - LINE_CNT_W'(latch_master_addr_cmd_idx);
         eol_reg <= (latch_master_addr_cmd_idx == LINE_IDX_W'(LINE_DW - 1));
      end else if (PCI_EOL_DEC_MAP[i_pci_cmd_lines] && line_left_reg > LINE_CNT_W'(1)) begin
         line_left_reg <= line_left_reg - LINE_CNT_W'(1);
         eol_reg <= (line_left_reg == LINE_CNT_W'(2));
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         post_addr_reg <= '0;
      end else if (pci_post_addr) begin
         post_addr_reg <= master_addr_reg;
      end
   end

   assign o_end_of_line_warning = eol_reg;
   assign o_post_write_addr = post_addr_reg;

   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   host_addr_lag_a: assert property (host_drive |-> ##1 o_host_addr_oe)
      else $error("host address not driven one cycle after drive");
   host_data_lag_a: assert property (host_drive |-> ##2 o_host_data_oe)
      else $error("host data not driven two cycles after drive");
   host_addr_rel_a: assert property (host_idle |=> !o_host_addr_oe)
      else $error("host address not released after idle");
   host_data_hold_a: assert property (
      o_host_data_oe && !(host_idle && i_mem_data_latch_en) |=> o_host_data_oe)
      else $error("host data released without idle and latch enable");
   host_data_rel_a: assert property (
      host_idle && i_mem_data_latch_en && !host_data_arm_reg |=> !o_host_data_oe)
      else $error("host data not released on idle with latch enable");
   cmr_source_a: assert property (
      host_cmr ##1 !host_drive |-> o_host_data_bus == mem_hold_reg[DATA_W-1:0])
      else $error("memory register not driven on host bus");
   mem_reg_load_a: assert property (
      i_mem_data_latch_en |=> mem_hold_reg[DATA_W-1:0] == $past(i_mem_data_bus))
      else $error("memory register did not load");
   mem_reg_keep_a: assert property (!i_mem_data_latch_en |=> $stable(mem_hold_reg))
      else $error("memory register changed without latch enable");
   mem_capture_a: assert property (mem_latch |=> o_mem_read_data == $past(i_mem_data_bus))
      else $error("memory data not captured on latch command");
   mem_drive_a: assert property (mem_retire |=> o_mem_data_oe)
      else $error("memory bus not driven after retire");
   mem_hold_a: assert property (
      o_mem_data_oe && mem_hold |=> o_mem_data_oe && $stable(o_mem_data_bus))
      else $error("retired data not held under hold-drive");
   mem_release_a: assert property (mem_idle |=> !o_mem_data_oe)
      else $error("memory bus not released on idle");
   pci_drive_a: assert property (
      i_pci_drive_enable ##1 i_pci_drive_enable |-> o_pci_ad_oe)
      else $error("AD not driven the cycle after drive enable");
   pci_release_a: assert property (!i_pci_drive_enable |-> !o_pci_ad_oe)
      else $error("AD still driven while drive enable low");
   par_in_a: assert property (
      !PCI_PAR_OUT_MAP[i_pci_cmd_lines] |=> o_pci_parity_out == $past(ad_par))
      else $error("inbound parity not one clock after data");
   par_out_a: assert property (PCI_PAR_OUT_MAP[i_pci_cmd_lines] |=> o_pci_parity_out == tx_par)
      else $error("outbound parity not aligned with driven data");
   pf_same_a: assert property (pf_a ##1 pf_a |=> $stable(pf_wr_ptr))
      else $error("repeated prefetch latch moved the slot");
   pf_advance_a: assert property (
      pf_a ##1 pf_b |=> pf_wr_ptr == PF_PTR_W'($past(pf_wr_ptr) + 1'b1))
      else $error("toggle change did not advance prefetch slot");
   pf_first_a: assert property (pf_first |=> pf_wr_ptr == '0)
      else $error("first prefetch latch did not reset the slot");
   eol_last_a: assert property (
      pci_latch_master_addr_cmd |=> o_end_of_line_warning == ($past(latch_master_addr_cmd_idx) == LINE_IDX_W'(LINE_DW - 1)))
      else $error("end-of-line warning wrong after address latch");

   host_read_c: cover property (host_cmr ##2 o_host_data_oe ##[1:8] (host_idle && i_mem_data_latch_en));
   mem_write_c: cover property (mem_retire ##1 mem_hold [*2] ##1 mem_idle);
   pf_toggle_c: cover property (pf_first ##1 pf_a ##1 pf_b ##1 pf_a);
   eol_c: cover property (pci_latch_master_addr_cmd ##1 o_end_of_line_warning);
endmodule
`default_nettype wire

// [test/mem_pci_partner.sv]
// Far-side model: memory data/parity lines and PCI AD lines.
// Assumes the bench offers one fresh word every core clock.
`timescale 1ns/1ps
`default_nettype none
module mem_pci_partner (
   input wire logic i_core_clk,
   input wire logic [31:0] i_word,
   output logic [31:0] o_mem_data,
   output logic [3:0] o_mem_par,
   output logic [31:0] o_ad
);
   initial begin
      o_mem_data = 32'h0;
      o_mem_par = 4'h0;
      o_ad = 32'h0;
   end
   // Lines change every cycle so a stale capture never matches by luck
   always @(posedge i_core_clk) begin
      o_ad <= i_word;
      o_mem_data <= ~i_word;
      o_mem_par <= {^i_word[31:24], ^i_word[23:16], ^i_word[15:8], ^i_word[7:0]};
   end
endmodule
`default_nettype wire

// [test/bridge_datapath_command_timing_bench.sv]
// Self-checking bench for the bridge data-path slice.
// Assumes the partner registers one word per cycle.
`timescale 1ns/1ps
`default_nettype none
module bridge_datapath_command_timing_bench;
   import bridge_dp_pkg::*;
   logic clk = 0, rst = 1, le = 0, wv = 0, pe = 0, hao, hdo, moe, mrv, rdy, poe, end_of_line_warning;
   logic [4:0] hc = 5'h00;
   logic [3:0] pc = 4'h0, mp, hp, mpo, wp = 4'h0, pp;
   logic [2:0] mc = 3'h0;
   logic [31:0] w = 32'h0, wd = 32'h0, tx = 32'h0, s = 32'h00014A05, ora = 32'h0, anda = 32'hFFFFFFFF;
   logic [31:0] md, ad, hd, mdo, mrd, pad, pwa, x;
   logic [31:0] q[2], sl[4];
   int fail_count = 0, cmp_count = 0, p;
   always #10 clk = ~clk;
   mem_pci_partner mem_pci_partner_i (.i_core_clk(clk), .i_word(w), .o_mem_data(md), .o_mem_par(mp), .o_ad(ad));
   bridge_datapath_command_timing bridge_datapath_command_timing_i (.i_core_clk(clk), .i_rst(rst),
      .i_host_cmd_lines(hc), .i_mem_data_latch_en(le), .o_host_addr_oe(hao), .o_host_data_bus(hd),
      .o_host_parity_bus(hp), .o_host_data_oe(hdo), .i_mem_cmd_lines(mc), .i_mem_data_bus(md),
      .i_mem_parity_bus(mp), .o_mem_data_bus(mdo), .o_mem_parity_bus(mpo), .o_mem_data_oe(moe),
      .o_mem_read_data(mrd), .o_mem_read_valid(mrv), .i_wr_data(wd), .i_wr_parity(wp), .i_wr_valid(wv),
      .o_wr_ready(rdy), .i_pci_cmd_lines(pc), .i_pci_drive_enable(pe), .i_pci_ad(ad), .i_pci_tx_data(tx),
      .o_pci_ad(pad), .o_pci_ad_oe(poe), .o_pci_parity_out(pp), .o_end_of_line_warning(end_of_line_warning),
      .o_post_write_addr(pwa));
   function automatic logic [3:0] par(input logic [31:0] v);
      return {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]};
   endfunction
   function automatic logic [31:0] nx(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   // Wide enough that a flag joined to a data word is compared too
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         s = nx(s);
         w = s & anda | ora;
         tx = ~s;
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d compares %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      tick(6);
      rst = 0;
      tick(1);
      chk(rdy, 1);
      hc = CPU_MEM_READ_CMD;
      tick(1);
      chk({hao, hdo}, 2'b10);
      tick(1);
      chk({hao, hdo}, 2'b11);
      x = md;
      le = 1;
      tick(1);
      le = 0;
      chk(hd, x);
      chk(hp, par(x));
      hc = HOST_IDLE_CMD;
      tick(2);
      chk({hao, hdo}, 2'b01);
      chk(hd, x);
      le = 1;
      tick(1);
      le = 0;
      chk(hdo, 0);
      for (p = 0; p < 2; p++) begin
         mc = p ? MEM_READ_NEXT_QW_LATCH : MEM_READ_FIRST_QW_LATCH;
         x = md;
         tick(1);
         chk({mrv, mrd}, {1'b1, x});
      end
      // Three idle cycles of turnaround; the buffer fills meanwhile
      mc = MEM_IDLE_CMD;
      wv = 1;
      for (p = 0; p < 3; p++) begin
         wd = s;
         wp = par(s);
         if (p < 2) begin
            q[p] = s;
         end
         tick(1);
      end
      wv = 0;
      chk(rdy, 0);
      for (p = 0; p < 3; p++) begin
         mc = RETIRE_CPU_WRITE_QW + p[2:0];
         tick(1);
         mc = MEM_HOLD_DRIVE_CMD;
         chk({moe, mdo}, {1'b1, q[p > 0]});
         chk(mpo, par(q[p > 0]));
         tick(2);
         chk({moe, mdo}, {1'b1, q[p > 0]});
         mc = MEM_IDLE_CMD;
         tick(1);
         chk(moe, 0);
      end
      chk(rdy, 1);
      pe = 1;
      #1 chk(poe, 0);
      tick(1);
      chk(poe, 1);
      pc = 4'h4;
      x = tx;
      tick(1);
      chk({par(x), pad}, {pp, x});
      pe = 0;
      #1 chk(poe, 0);
      tick(1);
      // Each latch command held a random count, as if waiting for target ready
      for (p = 0; p < 4; p++) begin
         pc = p == 0 ? PREFETCH_LATCH_FIRST : p[0] ? PREFETCH_LATCH_TOGGLE_A : PREFETCH_LATCH_TOGGLE_B;
         repeat (1 + s[1:0]) begin
            x = ad;
            tick(1);
            sl[p] = x;
            chk(pp, par(x));
         end
      end
      pc = LATCH_MASTER_ADDR_CMD;
      for (p = 0; p < 5; p++) begin
         hc = p == 0 ? HOST_PREFETCH_FIRST_CMD : p == 3 ? HOST_PREFETCH_TOGGLE_B_CMD : HOST_PREFETCH_TOGGLE_A_CMD;
         tick(2);
         chk(hd, sl[p - (p > 1)]);
      end
      pc = PREFETCH_LATCH_TOGGLE_A;
      x = ad;
      tick(1);
      pc = LATCH_MASTER_ADDR_CMD;
      chk(hd, x);
      chk(hp, par(x));
      for (p = 0; p < 2; p++) begin
         ora = p ? 32'h0 : 32'h1C;
         anda = p ? ~32'h1C : 32'hFFFFFFFF;
         tick(4);
         chk(end_of_line_warning, !p);
      end
      // Frozen address at dword index 6: one posted dword reaches the line end
      anda = 32'h0;
      ora = 32'h00001018;
      tick(4);
      chk(end_of_line_warning, 0);
      pc = POST_WRITE_ADDR_CMD;
      tick(1);
      chk(pwa, 32'h00001018);
      chk(end_of_line_warning, 1);
      finish_test();
   end
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule
`default_nettype wire
